// ===== hdl/shared_host_pkg.sv
// constants of the shared host register block
// -----------------------------------------------------------------------------
// What this block does
// - local processor sees every shared byte 8000H-FFFFH; host uses odd addresses only
// - host access selects card when address bits 21-23 are 011 and select code matches
// - shared area: registers 8000H, RAM one A000H, RAM two C000H, E000H unused
// - host write of bit 7 resets card, raises local nmi; local reset clears it
// - identity read: variant bit 7, bit 5 one, card code in bits 0-4
// - host write bit 7 of interrupt register sets or clears enable flip-flop
// - interrupt read: enable bit 7, request bit 6, level bits 4-5, zeros 0-3
// - lock reads busy in bit 7, sets after each read, any write releases
// - line control bits 7 and 6 select internal receive and transmit clocks
// - line control bits 2-5 drive optional outputs, bit 1 TR, bit 0 RS
// - line status bit 5 reflects serial controller channel A wait line
// - line status bits 3-4 optional inputs, bit 2 CS, bit 1 RR, bit 0 DM
// - local write of host doorbell raises host request; host read clears it
// - host write of local doorbell interrupts local processor; local read clears it
// - local io B0H-B3H select counter-timer channels 0-3
// - local io D0H reads upper switch nibble, D1H lower nibble
// - counter-timer channel 2 period is constant times 4.34 or 69.4 microseconds
// - counter-timer channel 2 output clocks serial controller channel B transmitter
// - clock select bits steer baud multiplexer between counter-timer and remote clocks
// - arbiter runs on oscillator 7.3728 MHz divided by two
// -----------------------------------------------------------------------------
package shared_host_pkg;
  // host space
  localparam logic [2:0] host_io_space = 3'b011;
  localparam logic [15:0] host_reset_id_off = 16'h0001;
  localparam logic [15:0] host_int_ctl_off = 16'h0003;
  localparam logic [15:0] host_lock_off = 16'h0005;
  localparam logic [15:0] host_line_off = 16'h0007;
  localparam logic [15:0] host_bell_off = 16'h4801;
  localparam logic [15:0] local_bell_off = 16'h4803;
  // local shared window, upper three address bits
  localparam logic [2:0] reg_region = 3'b100;
  localparam logic [2:0] ram1_region = 3'b101;
  localparam logic [2:0] ram2_region = 3'b110;
  // local io addresses
  localparam logic [7:0] io_serial_base = 8'h70;
  localparam logic [7:0] io_timer_base = 8'hB0;
  localparam logic [7:0] io_switch_hi = 8'hD0;
  localparam logic [7:0] io_switch_lo = 8'hD1;
  // field positions
  localparam int reset_bit = 7;
  localparam int smart_bit = 5;
  localparam int enable_bit = 7;
  localparam int request_bit = 6;
  localparam int busy_bit = 7;
  localparam int rx_clk_bit = 7;
  localparam int tx_clk_bit = 6;
  localparam int wait_bit = 5;
  // reset values
  localparam logic [7:0] line_ctl_reset = 8'h00;
  localparam logic lock_reset = 1'b0;
  // clocking
  localparam real osc_mhz = 7.3728;
  localparam real sys_mhz = osc_mhz / 2.0;
  localparam real tick16_us = 4.34;
  localparam real tick256_us = 69.4;
endpackage

// ===== hdl/shared_host_regs.sv
// shared host register block with local decode
`timescale 1ns/1ns
module shared_host_regs #(
  parameter logic [4:0] card_id = 5'h0_0A, // arbitrary value
  parameter logic remote_variant = 1'b0
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host port, synchronous single cycle strobes
  input wire logic [23:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [4:0] select_code,
  input wire logic [1:0] int_level,
  output logic [7:0] host_rdata,
  output logic host_sel,
  output logic host_irq,
  // local processor memory and io
  input wire logic [15:0] local_addr,
  input wire logic local_mem_rd,
  input wire logic local_mem_wr,
  input wire logic local_io_rd,
  input wire logic local_io_wr,
  input wire logic [7:0] local_wdata,
  output logic [7:0] local_rdata,
  output logic local_nmi,
  output logic local_irq,
  output logic card_reset,
  // chip selects
  output logic rom_sel,
  output logic ram1_sel,
  output logic ram2_sel,
  output logic [3:0] serial_sel,
  output logic [3:0] timer_sel,
  // switches and line
  input wire logic [7:0] switches,
  input wire logic serial_wait,
  input wire logic [1:0] optional_line_in,
  input wire logic line_cs,
  input wire logic line_rr,
  input wire logic line_dm,
  output logic [3:0] optional_line_out,
  output logic line_tr,
  output logic line_rs,
  // baud clock multiplexer
  input wire logic [1:0] timer_baud,
  input wire logic [1:0] remote_baud,
  input wire logic timer2_out,
  output logic rx_baud_clk,
  output logic tx_baud_clk,
  output logic serial_b_tx_clk
);
  // ---------------------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------------------
  logic host_hit;
  logic [15:0] hoff;
  logic [14:0] lword;
  logic [15:0] host_as_local;
  logic reg_local;
  logic [7:0] reset_id_r;
  logic [7:0] int_ctl_r;
  logic [7:0] lock_r;
  logic [7:0] line_r;
  logic reset_q;
  logic enable_q;
  logic host_req_q;
  logic local_req_q;
  logic busy_q;
  logic [7:0] line_ctl_q;
  logic host_lock_rd;
  logic local_lock_rd;

  assign host_hit = host_addr[23:21] == shared_host_pkg::host_io_space
    && host_addr[20:16] == select_code;
  assign hoff = host_addr[15:0];
  // host word n is local byte 8000H+n; bit 00 must be one
  assign host_as_local = {1'b1, hoff[15:1]};
  assign lword = local_addr[14:0];
  assign reg_local = local_addr[15:13] == shared_host_pkg::reg_region;
  assign host_lock_rd = host_rd && host_hit && hoff == shared_host_pkg::host_lock_off;
  assign local_lock_rd = local_mem_rd && reg_local
    && local_addr == {1'b1, shared_host_pkg::host_lock_off[15:1]};

  // read values shared by both ports
  assign reset_id_r = {remote_variant, 1'b0, 1'b1, card_id};
  assign int_ctl_r = {enable_q, host_req_q, int_level, 4'h0};
  assign lock_r = {busy_q, 7'h00};
  assign line_r = {2'b00, serial_wait, optional_line_in, line_cs, line_rr, line_dm};

  function automatic logic [7:0] reg_read(input logic [15:0] off);
    logic [7:0] v;
    v = 8'h00;
    unique case (off)
      shared_host_pkg::host_reset_id_off: v = reset_id_r;
      shared_host_pkg::host_int_ctl_off: v = int_ctl_r;
      shared_host_pkg::host_lock_off: v = lock_r;
      shared_host_pkg::host_line_off: v = line_r;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------------------
  // host side registers
  // ---------------------------------------------------------------------------
  // card reset bit: host sets, local reset routine clears; host write wins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reset_q <= 1'b0;
    end else if (host_wr && host_hit && hoff == shared_host_pkg::host_reset_id_off) begin
      reset_q <= host_wdata[shared_host_pkg::reset_bit];
    end else if (local_mem_wr && reg_local && lword == 15'h0000) begin
      reset_q <= local_wdata[shared_host_pkg::reset_bit];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      enable_q <= 1'b0;
    end else if (host_wr && host_hit && hoff == shared_host_pkg::host_int_ctl_off) begin
      enable_q <= host_wdata[shared_host_pkg::enable_bit];
    end
  end

  // lock: host read wins a simultaneous race, local then sees busy
  // arbitration runs on the single system clock, no second domain
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_q <= shared_host_pkg::lock_reset;
    end else if (host_lock_rd || local_lock_rd) begin
      busy_q <= 1'b1;
    end else if ((host_wr && host_hit && hoff == shared_host_pkg::host_lock_off)
        || (local_mem_wr && reg_local
        && local_addr == {1'b1, shared_host_pkg::host_lock_off[15:1]})) begin
      busy_q <= 1'b0;
    end
  end

  // line control is written by either port; local has priority
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      line_ctl_q <= shared_host_pkg::line_ctl_reset;
    end else if (local_mem_wr && reg_local
        && local_addr == {1'b1, shared_host_pkg::host_line_off[15:1]}) begin
      line_ctl_q <= local_wdata;
    end else if (host_wr && host_hit && hoff == shared_host_pkg::host_line_off) begin
      line_ctl_q <= host_wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // doorbells, set wins over clear
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_req_q <= 1'b0;
    end else if (local_mem_wr && local_addr == {1'b1, shared_host_pkg::host_bell_off[15:1]}) begin
      host_req_q <= 1'b1;
    end else if (host_rd && host_hit && hoff == shared_host_pkg::host_bell_off) begin
      host_req_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      local_req_q <= 1'b0;
    end else if (host_wr && host_hit && hoff == shared_host_pkg::local_bell_off) begin
      local_req_q <= 1'b1;
    end else if (local_mem_rd
        && local_addr == {1'b1, shared_host_pkg::local_bell_off[15:1]}) begin
      local_req_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      host_rdata <= 8'h00;
      host_sel <= 1'b0;
      host_irq <= 1'b0;
    end else begin
      host_sel <= host_hit && (host_rd || host_wr);
      host_rdata <= (host_rd && host_hit) ? reg_read(hoff) : 8'h00;
      host_irq <= enable_q && host_req_q;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      local_rdata <= 8'h00;
    end else if (local_io_rd && local_addr[7:0] == shared_host_pkg::io_switch_hi) begin
      local_rdata <= {4'h0, switches[7:4]};
    end else if (local_io_rd && local_addr[7:0] == shared_host_pkg::io_switch_lo) begin
      local_rdata <= {4'h0, switches[3:0]};
    end else if (local_mem_rd && reg_local) begin
      // a host lock read in the same cycle wins, so local must see busy
      local_rdata <= reg_read({lword[14:0], 1'b1})
        | ((host_lock_rd && local_lock_rd) ? 8'h80 : 8'h00);
    end else begin
      local_rdata <= 8'h00;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      local_nmi <= 1'b0;
      local_irq <= 1'b0;
      card_reset <= 1'b0;
    end else begin
      local_nmi <= reset_q;
      card_reset <= reset_q;
      local_irq <= local_req_q;
    end
  end

  // memory selects: host accesses map onto the same bytes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rom_sel <= 1'b0;
      ram1_sel <= 1'b0;
      ram2_sel <= 1'b0;
    end else begin
      rom_sel <= (local_mem_rd || local_mem_wr) && !local_addr[15];
      ram1_sel <= ((local_mem_rd || local_mem_wr)
        && local_addr[15:13] == shared_host_pkg::ram1_region)
        || ((host_rd || host_wr) && host_hit
        && host_as_local[15:13] == shared_host_pkg::ram1_region);
      ram2_sel <= ((local_mem_rd || local_mem_wr)
        && local_addr[15:13] == shared_host_pkg::ram2_region)
        || ((host_rd || host_wr) && host_hit
        && host_as_local[15:13] == shared_host_pkg::ram2_region);
    end
  end

  // exact io decode so no two peripherals are enabled together
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_io
      always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          serial_sel[ch] <= 1'b0;
          timer_sel[ch] <= 1'b0;
        end else begin
          serial_sel[ch] <= (local_io_rd || local_io_wr)
            && local_addr[7:0] == shared_host_pkg::io_serial_base + 8'(ch);
          timer_sel[ch] <= (local_io_rd || local_io_wr)
            && local_addr[7:0] == shared_host_pkg::io_timer_base + 8'(ch);
        end
      end
    end
  endgenerate

  // line outputs and baud multiplexer
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      optional_line_out <= 4'h0;
      line_tr <= 1'b0;
      line_rs <= 1'b0;
      rx_baud_clk <= 1'b0;
      tx_baud_clk <= 1'b0;
      serial_b_tx_clk <= 1'b0;
    end else begin
      optional_line_out <= line_ctl_q[5:2];
      line_tr <= line_ctl_q[1];
      line_rs <= line_ctl_q[0];
      // clocks resampled on mclk: limits baud clocks to well below mclk/2
      rx_baud_clk <= line_ctl_q[shared_host_pkg::rx_clk_bit] ? timer_baud[1] : remote_baud[1];
      tx_baud_clk <= line_ctl_q[shared_host_pkg::tx_clk_bit] ? timer_baud[0] : remote_baud[0];
      // timer 2 period is set by its own constant; only its output passes here
      serial_b_tx_clk <= timer2_out;
    end
  end
endmodule // shared_host_regs

// ===== dv/shared_host_regs_monitor.sv
// assertion checker for the shared host register block
`timescale 1ns/1ns
module shared_host_regs_monitor (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // host port
  input wire logic [23:0] host_addr,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [4:0] select_code,
  input wire logic [7:0] host_rdata,
  input wire logic host_sel,
  // local side
  input wire logic [15:0] local_addr,
  input wire logic local_mem_rd,
  input wire logic local_mem_wr,
  input wire logic local_io_rd,
  input wire logic local_io_wr,
  input wire logic local_nmi,
  input wire logic card_reset,
  input wire logic ram1_sel,
  input wire logic ram2_sel,
  input wire logic [3:0] serial_sel,
  input wire logic [3:0] timer_sel
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  wire logic hit = host_addr[23:21] == 3'b011 && host_addr[20:16] == select_code;
  wire logic mem = local_mem_rd | local_mem_wr;
  wire logic io = local_io_rd | local_io_wr;
  wire logic lock_rd = host_rd && hit && host_addr[15:0] == 16'h0005 && !local_mem_wr;
  property p_ram1;
    mem && local_addr[15:13] == 3'b101 |=> ram1_sel;
  endproperty
  a_ram1: assert property (p_ram1) else $error("ram one select missing");
  property p_ram2;
    mem && local_addr[15:13] == 3'b110 |=> ram2_sel && !ram1_sel;
  endproperty
  a_ram2: assert property (p_ram2) else $error("ram two select missing");
  property p_serial;
    io && (local_addr[7:0] & 8'hFC) == 8'h70 |=> serial_sel == 4'h1 << $past(local_addr[1:0]);
  endproperty
  a_serial: assert property (p_serial) else $error("serial select wrong");
  property p_timer;
    io && (local_addr[7:0] & 8'hFC) == 8'hB0 |=> timer_sel == 4'h1 << $past(local_addr[1:0]);
  endproperty
  a_timer: assert property (p_timer) else $error("timer select wrong");
  property p_sel;
    (host_rd | host_wr) && hit |=> host_sel;
  endproperty
  a_sel: assert property (p_sel) else $error("card not selected");
  property p_nosel;
    (host_rd | host_wr) && !hit |=> !host_sel;
  endproperty
  a_nosel: assert property (p_nosel) else $error("foreign access selected card");
  property p_lock;
    lock_rd ##1 lock_rd |=> host_rdata[7];
  endproperty
  a_lock: assert property (p_lock) else $error("second lock read not busy");
  property p_nmi;
    local_nmi == card_reset;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi and card reset disagree");
endmodule // shared_host_regs_monitor

bind shared_host_regs shared_host_regs_monitor i_shared_host_regs_monitor (.mclk, .rstn,
  .host_addr, .host_rd, .host_wr, .select_code, .host_rdata, .host_sel, .local_addr,
  .local_mem_rd, .local_mem_wr, .local_io_rd, .local_io_wr, .local_nmi, .card_reset,
  .ram1_sel, .ram2_sel, .serial_sel, .timer_sel);

// ===== dv/host_cpu_model.sv
// behavioural host processor driving the card's host port
`timescale 1ns/1ns
module host_cpu_model #(
  parameter logic [4:0] card_code = 5'h03
) (
  // clock
  input wire logic mclk,
  // host bus
  output logic [23:0] host_addr,
  output logic host_rd,
  output logic host_wr,
  output logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata
);
  initial begin
    host_addr = 24'h00_0000;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_wdata = 8'h00;
  end
  // n back-to-back strobes; q holds the data of the last one
  task automatic host_op(input logic wr, input logic [15:0] off, input logic [7:0] d,
      input int n, output logic [7:0] q);
    @(negedge mclk);
    host_addr = {3'b011, card_code, off[15:1], 1'b1};
    host_rd = !wr;
    host_wr = wr;
    host_wdata = d;
    repeat (n) @(negedge mclk);
    // read data stands for one cycle only, so take it before releasing
    q = host_rdata;
    host_rd = 1'b0;
    host_wr = 1'b0;
    // a released bus must not keep showing the last value
    host_wdata = ~d;
    host_addr = ~host_addr;
    @(negedge mclk);
  endtask
endmodule // host_cpu_model

// ===== dv/shared_host_regs_test.sv
// self-checking testbench of the shared host register block
`timescale 1ns/1ns
module shared_host_regs_test;
  logic mclk, rstn, host_rd, host_wr, host_sel, host_irq, local_mem_rd, local_mem_wr;
  logic local_io_rd, local_io_wr, local_nmi, local_irq, card_reset, rom_sel, ram1_sel;
  logic ram2_sel, serial_wait, line_cs, line_rr, line_dm, line_tr, line_rs, timer2_out;
  logic rx_baud_clk, tx_baud_clk, serial_b_tx_clk;
  logic [23:0] host_addr;
  logic [15:0] local_addr;
  logic [7:0] host_wdata, host_rdata, local_wdata, local_rdata, switches, q, q2;
  logic [4:0] select_code;
  logic [3:0] serial_sel, timer_sel, optional_line_out;
  logic [1:0] int_level, optional_line_in, timer_baud, remote_baud;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  shared_host_regs #(.card_id(5'h15), .remote_variant(1'b0)) i_shared_host_regs (.mclk,
    .rstn, .host_addr, .host_rd, .host_wr, .host_wdata, .select_code, .int_level,
    .host_rdata, .host_sel, .host_irq, .local_addr, .local_mem_rd, .local_mem_wr,
    .local_io_rd, .local_io_wr, .local_wdata, .local_rdata, .local_nmi, .local_irq,
    .card_reset, .rom_sel, .ram1_sel, .ram2_sel, .serial_sel, .timer_sel, .switches,
    .serial_wait, .optional_line_in, .line_cs, .line_rr, .line_dm, .optional_line_out,
    .line_tr, .line_rs, .timer_baud, .remote_baud, .timer2_out, .rx_baud_clk,
    .tx_baud_clk, .serial_b_tx_clk);
  host_cpu_model #(.card_code(5'h03)) i_host_cpu_model (.mclk, .host_addr, .host_rd,
    .host_wr, .host_wdata, .host_rdata);
  // --------------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    total_checks++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp}, 8'h01);
  endtask
  // s is {mem_rd, mem_wr, io_rd, io_wr}
  task automatic loc_op(input logic [3:0] s, input logic [15:0] a, input logic [7:0] d,
      output logic [7:0] r);
    @(negedge mclk);
    {local_mem_rd, local_mem_wr, local_io_rd, local_io_wr} = s;
    local_addr = a;
    local_wdata = d;
    @(negedge mclk);
    r = local_rdata;
    {local_mem_rd, local_mem_wr, local_io_rd, local_io_wr} = 4'h0;
    local_wdata = ~d;
    @(negedge mclk);
  endtask
  // flag outputs trail their cause by two cycles
  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    {rstn, local_mem_rd, local_mem_wr, local_io_rd, local_io_wr} = 5'h00;
    {local_addr, local_wdata, switches} = 32'h0000_00C5;
    // select code matches the host model; baud inputs distinct per path
    {select_code, int_level, optional_line_in, timer_baud, remote_baud} = 13'h0399;
    {serial_wait, line_cs, line_rr, line_dm, timer2_out} = 5'h1B;
    repeat (10) @(negedge mclk);
    rstn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      loc_op(4'h2, 16'h0070 + 16'(i), 8'h00, q);
      loc_op(4'h1, 16'h00B0 + 16'(i), 8'h00, q);
    end
    loc_op(4'h2, 16'h00D0, 8'h00, q);
    chk8(q, 8'h0C, 8'h0F);
    loc_op(4'h2, 16'h00D1, 8'h00, q);
    chk8(q, 8'h05, 8'h0F);
    loc_op(4'h8, 16'hA000, 8'h00, q);
    loc_op(4'h4, 16'hC000, 8'h00, q);
    $display("decode test done");
    i_host_cpu_model.host_op(1'b0, 16'h0001, 8'h00, 1, q);
    chk8(q, 8'h35, 8'hBF);
    loc_op(4'h8, 16'h8000, 8'h00, q);
    chk8(q, 8'h35, 8'hBF);
    i_host_cpu_model.host_op(1'b1, 16'h0003, 8'h7F, 1, q);
    i_host_cpu_model.host_op(1'b0, 16'h0003, 8'h00, 1, q);
    chk8(q, 8'h20, 8'hFF);
    i_host_cpu_model.host_op(1'b1, 16'h0003, 8'h80, 1, q);
    loc_op(4'h4, 16'hA400, 8'h11, q);
    settle;
    chk1(host_irq, 1'b1);
    i_host_cpu_model.host_op(1'b0, 16'h0003, 8'h00, 1, q);
    chk8(q, 8'hE0, 8'hFF);
    i_host_cpu_model.host_op(1'b0, 16'h4801, 8'h00, 1, q);
    settle;
    chk1(host_irq, 1'b0);
    i_host_cpu_model.host_op(1'b1, 16'h4803, 8'h22, 1, q);
    settle;
    chk1(local_irq, 1'b1);
    loc_op(4'h8, 16'hA401, 8'h00, q);
    settle;
    chk1(local_irq, 1'b0);
    $display("interrupt test done");
    i_host_cpu_model.host_op(1'b1, 16'h0005, 8'h5A, 1, q);
    i_host_cpu_model.host_op(1'b0, 16'h0005, 8'h00, 1, q);
    chk8(q, 8'h00, 8'h80);
    i_host_cpu_model.host_op(1'b0, 16'h0005, 8'h00, 2, q);
    chk8(q, 8'h80, 8'h80);
    loc_op(4'h4, 16'h8002, 8'h00, q);
    fork
      i_host_cpu_model.host_op(1'b0, 16'h0005, 8'h00, 1, q);
      loc_op(4'h8, 16'h8002, 8'h00, q2);
    join
    chk8(q, 8'h00, 8'h80);
    chk8(q2, 8'h80, 8'h80);
    i_host_cpu_model.host_op(1'b1, 16'h0005, 8'h00, 1, q);
    select_code = 5'h09;
    i_host_cpu_model.host_op(1'b0, 16'h0005, 8'h00, 1, q);
    chk8(q, 8'h00, 8'hFF);
    select_code = 5'h03;
    i_host_cpu_model.host_op(1'b0, 16'h0005, 8'h00, 1, q);
    chk8(q, 8'h00, 8'h80);
    $display("lock test done");
    i_host_cpu_model.host_op(1'b1, 16'h0007, 8'hE9, 1, q);
    settle;
    chk8({optional_line_out, line_tr, line_rs, rx_baud_clk, tx_baud_clk}, 8'hA6, 8'hFF);
    loc_op(4'h4, 16'h8003, 8'h00, q);
    settle;
    chk8({optional_line_out, line_tr, line_rs, rx_baud_clk, tx_baud_clk}, 8'h01, 8'hFF);
    i_host_cpu_model.host_op(1'b0, 16'h0007, 8'h00, 1, q);
    chk8(q, 8'h2D, 8'h3F);
    chk1(serial_b_tx_clk, 1'b1);
    $display("line test done");
    i_host_cpu_model.host_op(1'b1, 16'h0001, 8'h80, 1, q);
    settle;
    chk1(local_nmi, 1'b1);
    loc_op(4'h4, 16'h8000, 8'h00, q);
    settle;
    chk1(card_reset, 1'b0);
    $display("reset test done");
    wrap_up;
  end
endmodule // shared_host_regs_test
